/* core/rsrc_ctrl.v */
/*
 Command interpreter of a 1024-position digital rheostat: serial frame
 receiver, wiper register, write protection, fifty-slot fuse memory,
 shutdown, software reset and next-frame readback on the serial output.
 Assumes the serial clock, frame select and data come from a host on another
 clock; they are sampled on CLK_I, which must run well above the link clock.
*/
`timescale 1ns/1ps
`include "rsrc_regs.vh"
// How it works
// RL1 - Shutdown command with data bit 0 set enters shutdown.
// RL2 - In shutdown the end terminal opens, wiper stays connected.
// RL3 - All commands still decode and run during shutdown.
// RL4 - Shutdown with bit 0 clear, or software reset, leaves shutdown.
// RL5 - Software reset loads the wiper from the newest programmed slot.
// RL6 - With no slot programmed, software reset loads midscale.
// RL7 - Control word is ten bits: success D3, unlock D1, enable D0.
// RL8 - Enable defaults to zero; store programs only when it is one.
// RL9 - Unlock defaults to zero; wiper writes are ignored until set.
// RL10 - Success flag starts zero and reads one after a good store.
// RL11 - Locked and unprogrammed, the wiper stays at midscale.
// RL12 - Memory address is D6..D0; slots 0x01 to 0x32 hold stores.
// RL13 - Addresses 0x39 and 0x3A return the tolerance words.
// RL14 - Host sends 0x1C03 before wiper updates or stores take effect.
// RL15 - Wiper write loads its ten data bits into the wiper.
// RL16 - After wiper read, next frame ends with the ten wiper bits.
// RL17 - Store copies the wiper into the next free fuse slot.
// RL18 - After last-address command, next frame low six bits give address.
// RL19 - After memory read, next frame ends with the slot contents.
// RL20 - After control read, next frame ends with the control word.
// RL21 - Without readback, output repeats the previous frame's word.
// RL22 - Frames are sixteen bits, MSB first, decoded on select rising.
// RL23 - A store lasts 350 ms and locks the shift register meanwhile.
// RL24 - First store goes to slot 0x01, then one higher each time.
// RL25 - Control write takes only D1 and D0; success is read-only.
// RL26 - Refused stores leave memory and the success flag untouched.
// RL27 - Shutdown is clear after power-on reset.
module rsrc_ctrl
#(
   parameter [31:0] STORE_CYCLES = `RSRC_STORE_CYCLES,
   parameter [9:0] TOL_UPPER = 10'h000,
   parameter [9:0] TOL_LOWER = 10'h000
)
(
   input wire CLK_I,
   input wire RESETN_I,
   input wire SCLK_I,
   input wire SYNCN_I,
   input wire DIN_I,
   output reg SERIAL_READBACK_OUT_O,
   output reg [9:0] WIPER_O,
   output reg END_TERMINAL_CONNECT_O,
   output reg WIPER_CONNECT_O,
   output reg STORE_BUSY_O
);
   wire sclk_s;
   wire syncn_s;
   wire din_s;
   reg sclk_d;
   reg syncn_d;
   reg [15:0] shift_in;
   reg [15:0] shift_out;
   reg [4:0] bit_count;
   reg [9:0] wiper;
   reg unlock;
   reg enable;
   reg success;
   reg shutdown;
   reg [5:0] last_slot;
   reg [9:0] fuse_mem [0:`RSRC_SLOTS-1];
   reg [31:0] store_timer;
   reg store_busy;
   reg [15:0] next_reply;
   reg [15:0] reply;
   wire sclk_rise;
   wire sclk_fall;
   wire frame_end;
   wire [3:0] cmd;
   wire [9:0] data;
   wire [9:0] last_value;
   wire store_go;
   wire store_done;
   genvar gi;
   // Store sequencer states; the busy flag is the state itself.
   localparam ST_IDLE = 1'b0;
   localparam ST_PROGRAM = 1'b1;

   // Synchronise the link pins; the serial clock is sampled, not a clock.
   rsrc_sync #(.RESET_VALUE(1'b0)) u_sync_sclk
   (
      .clk_i(CLK_I),
      .resetn_i(RESETN_I),
      .d_i(SCLK_I),
      .q_o(sclk_s)
   );
   rsrc_sync #(.RESET_VALUE(1'b1)) u_sync_syncn
   (
      .clk_i(CLK_I),
      .resetn_i(RESETN_I),
      .d_i(SYNCN_I),
      .q_o(syncn_s)
   );
   rsrc_sync #(.RESET_VALUE(1'b0)) u_sync_din
   (
      .clk_i(CLK_I),
      .resetn_i(RESETN_I),
      .d_i(DIN_I),
      .q_o(din_s)
   );

   // Edge detection on the synchronised copies only.
   always @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         sclk_d <= 1'b0;
         syncn_d <= 1'b1;
      end
      else
      begin
         sclk_d <= sclk_s;
         syncn_d <= syncn_s;
      end
   end

   assign sclk_rise = sclk_s & ~sclk_d;
   assign sclk_fall = ~sclk_s & sclk_d;
   // A frame is accepted only if exactly a multiple of sixteen bits came in.
   assign frame_end = syncn_s & ~syncn_d & (bit_count == 5'h10); // [RL22]
   assign cmd = shift_in[13:10];
   assign data = shift_in[9:0];

   // Value of the newest programmed slot, or midscale when none.
   function [9:0] rsrc_slot_value;
      input [5:0] slot;
      input [9:0] stored;
      begin
         if (slot == 6'h00)
            rsrc_slot_value = `RSRC_MIDSCALE; // [RL6] [RL11]
         else
            rsrc_slot_value = stored;
      end
   endfunction

   assign last_value = rsrc_slot_value(last_slot,
      fuse_mem[(last_slot == 6'h00) ? 6'h00 : last_slot - 6'h01]); // [RL5]

   // Memory map read; the reserved word and gaps read as zero.
   function [9:0] rsrc_mem_read;
      input [6:0] addr;
      input [5:0] used;
      input [9:0] stored;
      begin
         if (addr >= `RSRC_ADDR_FIRST && addr <= `RSRC_ADDR_LAST && addr[5:0] <= used)
            rsrc_mem_read = stored; // [RL12]
         else if (addr == `RSRC_ADDR_TOL_UPPER)
            rsrc_mem_read = TOL_UPPER; // [RL13]
         else if (addr == `RSRC_ADDR_TOL_LOWER)
            rsrc_mem_read = TOL_LOWER; // [RL13]
         else
            rsrc_mem_read = 10'h000;
      end
   endfunction

   // Store acceptance, shared by the sequencer, the flags and the slot writes.
   // A refused store is silently dropped, so the host must poll the flag.
   function rsrc_store_ok;
      input busy;
      input [3:0] code;
      input prog_en;
      input [5:0] used;
      begin
         rsrc_store_ok = !busy && code == `RSRC_CMD_STORE && prog_en
            && used < `RSRC_SLOTS; // [RL8] [RL26]
      end
   endfunction

   assign store_go = frame_end & rsrc_store_ok(store_busy, cmd, enable, last_slot); // [RL17]
   assign store_done = (store_busy == ST_PROGRAM) && (store_timer == STORE_CYCLES - 32'h1);

   // Next-frame answer: readback result, else an echo of this frame.
   always @*
   begin
      next_reply = shift_in; // [RL21]
      case (cmd)
         `RSRC_CMD_WIPER_READ:
            next_reply = {6'h00, wiper}; // [RL16]
         `RSRC_CMD_MEM_READ:
            next_reply = {6'h00, rsrc_mem_read(data[6:0], last_slot,
               fuse_mem[data[5:0] - 6'h01])}; // [RL19] [RL12]
         `RSRC_CMD_LAST_ADDR:
            next_reply = {10'h000, last_slot}; // [RL18]
         `RSRC_CMD_CTRL_READ:
            next_reply = {12'h000, success, 1'b0, unlock, enable}; // [RL20] [RL7]
         default:
            next_reply = shift_in;
      endcase
   end

   // Serial shift: input on rising clock, output changes on falling clock.
   // The input register freezes while a store is in progress.
   always @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         shift_in <= 16'h0000;
         shift_out <= 16'h0000;
         bit_count <= 5'h00;
         reply <= 16'h0000;
         SERIAL_READBACK_OUT_O <= 1'b0;
      end
      else if (syncn_s)
      begin
         bit_count <= 5'h00;
         if (frame_end)
         begin
            reply <= next_reply;
         end
         shift_out <= frame_end ? next_reply : reply;
         SERIAL_READBACK_OUT_O <= frame_end ? next_reply[15] : reply[15];
      end
      else if (!store_busy)
      begin
         if (sclk_rise)
         begin
            shift_in <= {shift_in[14:0], din_s}; // [RL22] [RL23]
            bit_count <= (bit_count == 5'h10) ? 5'h01 : bit_count + 5'h01;
         end
         if (sclk_fall && bit_count != 5'h00)
         begin
            shift_out <= {shift_out[14:0], 1'b0};
            SERIAL_READBACK_OUT_O <= shift_out[14];
         end
      end
   end

   // Command execution on frame end; registers above the wiper logic.
   always @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         wiper <= `RSRC_MIDSCALE; // [RL11]
         unlock <= 1'b0; // [RL9]
         enable <= 1'b0; // [RL8]
         success <= 1'b0; // [RL10]
         shutdown <= 1'b0; // [RL27]
         last_slot <= 6'h00;
      end
      else
      begin
         if (store_done)
         begin
            // The flag is set only once the fixed store time has run out.
            success <= 1'b1; // [RL10]
            last_slot <= last_slot + 6'h01; // [RL24]
         end
         else if (frame_end && !store_busy)
         begin
            // Shutdown does not gate decoding here.
            case (cmd) // [RL3]
               `RSRC_CMD_WIPER_WRITE:
                  if (unlock)
                     wiper <= data; // [RL9] [RL15] [RL14]
               `RSRC_CMD_STORE:
                  if (store_go)
                     success <= 1'b0; // [RL8] [RL17] [RL14] [RL26]
               `RSRC_CMD_SOFT_RESET:
               begin
                  wiper <= last_value; // [RL5] [RL6]
                  shutdown <= 1'b0; // [RL4]
               end
               `RSRC_CMD_CTRL_WRITE:
               begin
                  unlock <= data[`RSRC_CTRL_UNLOCK_BIT]; // [RL25]
                  enable <= data[`RSRC_CTRL_ENABLE_BIT]; // [RL25]
               end
               `RSRC_CMD_SHUTDOWN:
                  shutdown <= data[0]; // [RL1] [RL4]
               default:
                  shutdown <= shutdown;
            endcase
         end
      end
   end

   // Fuse program sequencer; a fixed count stands in for the fuse blow time.
   // The real count is long, so a bench shortens it through STORE_CYCLES.
   always @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         store_busy <= ST_IDLE;
         store_timer <= 32'h0;
      end
      else
      begin
         case (store_busy)
            ST_IDLE:
            begin
               store_timer <= 32'h0;
               if (store_go)
                  store_busy <= ST_PROGRAM; // [RL17] [RL23]
            end
            ST_PROGRAM:
            begin
               store_timer <= store_timer + 32'h1;
               if (store_done)
                  store_busy <= ST_IDLE; // [RL23]
            end
            default:
               store_busy <= ST_IDLE;
         endcase
      end
   end

   // Fuse slots; each is written once, when its store is started.
   generate
      for (gi = 0; gi < `RSRC_SLOTS; gi = gi + 1)
      begin : g_slot
         always @(posedge CLK_I or negedge RESETN_I)
         begin
            if (!RESETN_I)
               fuse_mem[gi] <= 10'h000;
            else if (store_go && last_slot == gi)
               fuse_mem[gi] <= wiper; // [RL17] [RL24]
         end
      end
   endgenerate

   // Pin outputs; shutdown opens only the end terminal, saving current.
   always @(posedge CLK_I or negedge RESETN_I)
   begin
      if (!RESETN_I)
      begin
         WIPER_O <= `RSRC_MIDSCALE;
         END_TERMINAL_CONNECT_O <= 1'b1;
         WIPER_CONNECT_O <= 1'b1;
         STORE_BUSY_O <= 1'b0;
      end
      else
      begin
         WIPER_O <= wiper;
         END_TERMINAL_CONNECT_O <= ~shutdown; // [RL2]
         WIPER_CONNECT_O <= 1'b1; // [RL2]
         STORE_BUSY_O <= store_busy;
      end
   end
endmodule // rsrc_ctrl

/* core/rsrc_regs.vh */
/*
 Constants of the rheostat command block: command codes, frame layout,
 control word fields, fuse memory map and timing counts.
 Assumes it is included once per compile unit; the guard covers repeats.
*/
`ifndef RSRC_REGS_VH
`define RSRC_REGS_VH
`define RSRC_FRAME_BITS 16
`define RSRC_CMD_NOP 4'h0
`define RSRC_CMD_WIPER_WRITE 4'h1
`define RSRC_CMD_WIPER_READ 4'h2
`define RSRC_CMD_STORE 4'h3
`define RSRC_CMD_SOFT_RESET 4'h4
`define RSRC_CMD_MEM_READ 4'h5
`define RSRC_CMD_LAST_ADDR 4'h6
`define RSRC_CMD_CTRL_WRITE 4'h7
`define RSRC_CMD_CTRL_READ 4'h8
`define RSRC_CMD_SHUTDOWN 4'h9
`define RSRC_CTRL_ENABLE_BIT 0
`define RSRC_CTRL_UNLOCK_BIT 1
`define RSRC_CTRL_SUCCESS_BIT 3
`define RSRC_ADDR_RESERVED 7'h00
`define RSRC_ADDR_FIRST 7'h01
`define RSRC_ADDR_LAST 7'h32
`define RSRC_ADDR_TOL_UPPER 7'h39
`define RSRC_ADDR_TOL_LOWER 7'h3a
`define RSRC_SLOTS 50
`define RSRC_MIDSCALE 10'h200
`define RSRC_CLK_HZ 20000000
`define RSRC_STORE_TIME_MS 350
`define RSRC_STORE_CYCLES ((`RSRC_STORE_TIME_MS * (`RSRC_CLK_HZ / 1000)))
`endif

/* core/rsrc_sync.v */
/*
 Two flip-flop synchroniser for one level from outside the clock domain.
 Assumes the input may change at any time relative to CLK_I.
*/
`timescale 1ns/1ps
module rsrc_sync
#(
   parameter [0:0] RESET_VALUE = 1'b0
)
(
   input wire clk_i,
   input wire resetn_i,
   input wire d_i,
   output reg q_o
);
   reg stage1;

   // Only the second stage reads the first; nothing else may look at it.
   // Both stages reset to the pin's idle level, so no false edge follows reset.
   always @(posedge clk_i or negedge resetn_i)
   begin
      if (!resetn_i)
      begin
         stage1 <= RESET_VALUE;
         q_o <= RESET_VALUE;
      end
      else
      begin
         stage1 <= d_i;
         q_o <= stage1;
      end
   end
endmodule // rsrc_sync

/* dv/rsrc_ctrl_chk.sv */
/*
 Checker bound to the rheostat command block.
 Assumes one clock, CLK_I, and the asynchronous reset RESETN_I.
*/
`timescale 1ns/1ps
module rsrc_ctrl_chk
#(
   parameter [31:0] STORE_CYCLES = 32'd20
)
(
   input wire CLK_I,
   input wire RESETN_I,
   input wire SCLK_I,
   input wire SYNCN_I,
   input wire DIN_I,
   input wire SERIAL_READBACK_OUT_O,
   input wire [9:0] WIPER_O,
   input wire END_TERMINAL_CONNECT_O,
   input wire WIPER_CONNECT_O,
   input wire STORE_BUSY_O
);
   reg [3:0] age_sync;
   reg [3:0] age_edge;
   reg [31:0] busy_cnt;
   default clocking @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);
   // Ages saturate so that an old frame end never excuses a late change.
   always @(posedge CLK_I or negedge RESETN_I)
      if (!RESETN_I)
      begin
         age_sync <= 4'hf;
         age_edge <= 4'hf;
         busy_cnt <= 32'h0;
      end
      else
      begin
         age_sync <= $rose(SYNCN_I) ? 4'h0 : age_sync + {3'h0, ~&age_sync};
         age_edge <= ($fell(SCLK_I) || $changed(SYNCN_I)) ? 4'h0 : age_edge + {3'h0, ~&age_edge};
         busy_cnt <= STORE_BUSY_O ? busy_cnt + 32'h1 : 32'h0;
      end
   // Wiper, end terminal, store start and readback move only shortly after a frame or serial edge.
   reset_state_a: assert property ($rose(RESETN_I) |-> WIPER_O == 10'h200
      && END_TERMINAL_CONNECT_O && !STORE_BUSY_O) else $error("bad reset state");
   wiper_wired_a: assert property (WIPER_CONNECT_O) else $error("wiper cut");
   store_len_a: assert property (busy_cnt <= STORE_CYCLES
      && (!$fell(STORE_BUSY_O) || busy_cnt == STORE_CYCLES)) else $error("store length");
   store_freeze_a: assert property
      (STORE_BUSY_O && $past(STORE_BUSY_O) |-> $stable(WIPER_O)) else $error("wiper moved");
   wiper_cause_a: assert property ($changed(WIPER_O) |-> age_sync < 4'd10)
      else $error("wiper moved alone");
   end_cause_a: assert property
      ($changed(END_TERMINAL_CONNECT_O) |-> age_sync < 4'd10) else $error("end moved alone");
   store_cause_a: assert property ($rose(STORE_BUSY_O) |-> age_sync < 4'd10)
      else $error("store alone");
   readback_cause_a: assert property
      ($changed(SERIAL_READBACK_OUT_O) |-> age_edge < 4'd12) else $error("output moved alone");
endmodule // rsrc_ctrl_chk
bind rsrc_ctrl rsrc_ctrl_chk #(.STORE_CYCLES(STORE_CYCLES)) chk
(
   .CLK_I(CLK_I), .RESETN_I(RESETN_I), .SCLK_I(SCLK_I), .SYNCN_I(SYNCN_I), .DIN_I(DIN_I),
   .SERIAL_READBACK_OUT_O(SERIAL_READBACK_OUT_O), .WIPER_O(WIPER_O),
   .END_TERMINAL_CONNECT_O(END_TERMINAL_CONNECT_O),
   .WIPER_CONNECT_O(WIPER_CONNECT_O), .STORE_BUSY_O(STORE_BUSY_O)
);

/* dv/rsrc_ctrl_tb.sv */
/*
 Self-checking bench of the rheostat command block with a serial host model.
 Assumes the design, host and checker files are compiled before it.
*/
`timescale 1ns/1ps
module rsrc_ctrl_tb;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   wire sclk, sync_n, din, readback, endc, wcon, busy;
   wire [9:0] wiper;
   reg [31:0] seed = 32'h564d;
   reg [15:0] r;
   reg [9:0] w1, w2;
   integer failures = 0, n_compared = 0, i;
   // The 20 MHz clock.
   initial forever #25 clk = ~clk;
   rsrc_ctrl #(.STORE_CYCLES(32'd400), .TOL_UPPER(10'h00a), .TOL_LOWER(10'h0b0)) DUT
   (
      .CLK_I(clk), .RESETN_I(rst_n), .SCLK_I(sclk), .SYNCN_I(sync_n), .DIN_I(din),
      .SERIAL_READBACK_OUT_O(readback), .WIPER_O(wiper), .END_TERMINAL_CONNECT_O(endc),
      .WIPER_CONNECT_O(wcon), .STORE_BUSY_O(busy)
   );
   rsrc_host HOST (.clk_i(clk), .readback_i(readback), .sclk_o(sclk),
      .sync_n_o(sync_n), .din_o(din));
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // Control readback with unlock and enable set.
   function [15:0] ctl(input s);
      ctl = {12'h0, s, 3'b011};
   endfunction
   task check(input [15:0] seen, input [15:0] want);
      begin
         n_compared = n_compared + 1;
         failures = failures + (seen !== want);
         if (seen !== want)
            $display("ERROR t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask
   // One frame, an optional NOP that carries the answer, then a bounded store wait.
   task send(input [15:0] w, input nop);
      integer k;
      begin
         HOST.frame(w, r);
         if (nop)
            HOST.frame(16'h0000, r);
         for (k = 0; k < 900 && busy !== 1'b0; k = k + 1)
            @(negedge clk);
      end
   endtask
   task results;
      begin
         $display("compared %0d failures %0d", n_compared, failures);
         if (failures == 0 && n_compared > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // The run needs about a third of a millisecond; a hang is cut off well past that.
   initial
   begin
      #2000000;
      failures = failures + 1;
      results;
   end
   // Locked, unlocked, fuse and shutdown sequences in turn.
   initial
   begin
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      check({3'h0, wiper, endc, wcon, busy}, 16'h1006);
      send(16'h0555, 1'b0);
      send(16'h0c00, 1'b0);
      check(r, 16'h0555);
      send(16'h2000, 1'b1);
      check({2'h0, r[3:0], wiper}, 16'h0200);
      $display("locked tests done");
      send(16'h1c03, 1'b0);
      send(16'h0555, 1'b0);
      check({6'h0, wiper}, 16'h0155);
      send(16'h1000, 1'b0);
      check({6'h0, wiper}, 16'h0200);
      send(16'h1fff, 1'b0);
      send(16'h2000, 1'b1);
      check(r & 16'h000f, ctl(1'b0));
      for (i = 0; i < 4; i = i + 1)
      begin
         seed = lfsr(seed);
         w1 = (i == 0) ? 10'h3ff : seed[9:0];
         send({6'h01, w1}, 1'b0);
         check({6'h0, wiper}, {6'h0, w1});
         send(16'h0800, 1'b1);
         check(r & 16'h03ff, {6'h0, w1});
      end
      $display("wiper tests done");
      send(16'h0c00, 1'b0);
      send(16'h2000, 1'b1);
      check(r & 16'h000f, ctl(1'b1));
      send(16'h1781, 1'b1);
      check(r & 16'h03ff, {6'h0, w1});
      seed = lfsr(seed);
      w2 = seed[9:0];
      send({6'h01, w2}, 1'b0);
      HOST.frame(16'h0c00, r);
      HOST.frame({6'h01, ~w2}, r);
      send(16'h0000, 1'b0);
      send(16'h1800, 1'b1);
      check({r[5:0], wiper}, {6'h02, w2});
      send(16'h1439, 1'b1);
      check(r & 16'h03ff, 16'h000a);
      send(16'h143a, 1'b1);
      check(r & 16'h03ff, 16'h00b0);
      send({6'h01, ~w2}, 1'b0);
      send(16'h1000, 1'b0);
      check({6'h0, wiper}, {6'h0, w2});
      $display("fuse tests done");
      send(16'h2401, 1'b0);
      check({14'h0, endc, wcon}, 16'h0001);
      send({6'h01, w1}, 1'b0);
      check({6'h0, wiper}, {6'h0, w1});
      send(16'h2400, 1'b0);
      check({15'h0, endc}, 16'h0001);
      send(16'h2401, 1'b0);
      send(16'h1000, 1'b0);
      check({5'h0, endc, wiper}, {6'h01, w2});
      $display("shutdown tests done");
      results;
   end
endmodule // rsrc_ctrl_tb

/* dv/rsrc_host.sv */
/*
 Serial host model: sends frames MSB first and collects the returned word.
 Assumes the 20 MHz bench clock; it drives on that clock's falling edge.
*/
`timescale 1ns/1ps
module rsrc_host
(
   input wire clk_i,
   input wire readback_i,
   output reg sclk_o = 1'b0,
   output reg sync_n_o = 1'b1,
   output reg din_o = 1'b0
);
   // One frame of 400 ns bits; the clock rests low and data flips once released.
   task frame(input [15:0] w, output [15:0] r);
      integer i;
      begin
         @(negedge clk_i) sync_n_o = 1'b0;
         for (i = 15; i >= 0; i = i - 1)
         begin
            din_o = w[i];
            repeat (4) @(negedge clk_i);
            sclk_o = 1'b1;
            repeat (4) @(negedge clk_i);
            r[i] = readback_i;
            sclk_o = 1'b0;
         end
         repeat (4) @(negedge clk_i);
         sync_n_o = 1'b1;
         din_o = ~din_o;
         repeat (8) @(negedge clk_i);
      end
   endtask
endmodule // rsrc_host
